//--- src/fbp_pkg.sv
/*
  Package for the flash block protection logic: geometry, request and
  answer structs, access kinds and timing counts.
  Assumes a single 50 MHz system clock and an active-high async reset.
*/
package fbp_pkg;

  // Geometry of the array, in 32-bit words
  localparam int FBP_WORD_AW = 16;               // 256 KB / 4 B = 65536 words
  localparam int FBP_UNIT_AW = 8;                // 1 KB unit = 256 words
  localparam int FBP_UNITS = 256;                // 1 KB erase units
  localparam int FBP_PAIRS = 128;                // 2 KB protection pairs
  localparam int FBP_PAIR_W = 7;
  localparam int FBP_UNIT_W = 8;
  localparam int FBP_PAIR_LSB = 9;               // Word address bit that starts the pair index
  localparam int FBP_UNIT_LSB = 8;
  localparam logic [31:0] FBP_ERASED_WORD = 32'hFFFFFFFF;
  localparam logic [FBP_UNIT_AW-1:0] FBP_UNIT_LAST = 8'hFF;

  // Timing: program time, its cycle count derived from the clock
  localparam int FBP_CLK_MHZ = 50;
  localparam int FBP_PROG_TIME_NS = 40;
  localparam int FBP_PROG_CYC = (FBP_PROG_TIME_NS * FBP_CLK_MHZ + 999) / 1000;
  localparam int FBP_CNT_W = 4;

  // Who is asking
  typedef enum logic [1:0] {
    FBP_SRC_IFETCH = 2'h0,
    FBP_SRC_DATA = 2'h1,
    FBP_SRC_DEBUG = 2'h2
  } fbp_src_t;

  // What is asked
  typedef enum logic [1:0] {
    FBP_OP_READ = 2'h0,
    FBP_OP_PROGRAM = 2'h1,
    FBP_OP_ERASE = 2'h2
  } fbp_op_t;

  // Marking of one pair
  typedef struct packed {
    logic read_only;
    logic exec_only;
  } fbp_prot_t;

  typedef struct packed {
    fbp_src_t src;
    fbp_op_t op;
    logic [FBP_WORD_AW-1:0] addr;
    logic [31:0] wdata;
  } fbp_req_t;

  typedef struct packed {
    logic [31:0] rdata;
    logic violation;
  } fbp_rsp_t;

endpackage : fbp_pkg

//--- src/fbp_guard.sv
/*
  Protection check for one request against the per-pair markings.
  Assumes the marking vector is stable while a request is held.
*/
`timescale 1ns/100ps
module fbp_guard (
  input wire fbp_pkg::fbp_req_t req_in,
  input wire fbp_pkg::fbp_prot_t [fbp_pkg::FBP_PAIRS-1:0] prot_in,
  output logic deny_out
);
  import fbp_pkg::*;

  logic [FBP_PAIR_W-1:0] pair_idx;
  fbp_prot_t mark;
  logic is_write;

  // Two 1 KB units share one marking
  always_comb begin
    pair_idx = req_in.addr[FBP_WORD_AW-1:FBP_PAIR_LSB];
    mark = prot_in[pair_idx];
    is_write = (req_in.op != FBP_OP_READ);
    deny_out = 1'b0;
    if (is_write && (mark.read_only || mark.exec_only)) begin
      deny_out = 1'b1;
    end
    if (!is_write && mark.exec_only && (req_in.src != FBP_SRC_IFETCH)) begin
      deny_out = 1'b1;
    end
  end

endmodule : fbp_guard

//--- src/fbp_flash.sv
/*
  Flash array with 1 KB unit erase, word program, and 2 KB pair protection.
  Reads answer in one cycle; program and erase hold the requester off with
  ready low until their answer. Refused requests answer at once with the
  violation flag set and never reach the array.
  Assumes one requester at a time, an arbiter upstream, and markings set
  by system logic on prot_set_in (one pulse per change). The array has no
  reset, so a unit must be erased before its contents mean anything.
  Assumes req_in holds steady while req_valid_in is high and not yet taken,
  as all requesters sit on this same clock.
*/
`timescale 1ns/100ps
// Functional notes
// - 256 KB array, 1 KB independently erasable units
// - Erase leaves every unit bit one
// - Protection per pair of adjacent units
// - Read-only pair refuses erase and program
// - Execute-only pair refuses erase and program
// - Execute-only pair answers only instruction fetch
module fbp_flash (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic req_valid_in,
  input wire fbp_pkg::fbp_req_t req_in,
  output logic req_ready_out,
  output logic rsp_valid_out,
  output fbp_pkg::fbp_rsp_t rsp_out,
  input wire logic prot_set_in,
  input wire logic [fbp_pkg::FBP_PAIR_W-1:0] prot_pair_in,
  input wire fbp_pkg::fbp_prot_t prot_val_in,
  output logic busy_out
);
  import fbp_pkg::*;

  // Both busy states sit one bit away from idle, in and out
  typedef enum logic [1:0] {
    FBP_IDLE = 2'h0,
    FBP_PROG = 2'h1,
    FBP_ERASE = 2'h2
  } fbp_state_t;

  // Storage: one array for the whole flash
  logic [31:0] mem [0:(1<<FBP_WORD_AW)-1];

  // Request sequencing: state, held request, program timer, erase pointer
  fbp_state_t state_reg, state_next;
  fbp_req_t hold_reg, hold_next;
  logic [FBP_CNT_W-1:0] cnt_reg, cnt_next;
  logic [FBP_UNIT_AW-1:0] ptr_reg, ptr_next;

  // Answer registers; the data word stands until the next answer
  logic rsp_valid_reg, rsp_valid_next;
  fbp_rsp_t rsp_reg, rsp_next;

  // Pair markings, cleared by reset so every pair starts open
  fbp_prot_t [FBP_PAIRS-1:0] prot_reg, prot_next;

  // Handshake and array port
  logic deny;
  logic take;
  logic mem_we;
  logic [FBP_WORD_AW-1:0] mem_addr;
  logic [31:0] mem_wdata;
  logic [31:0] rd_word;
  logic [31:0] old_word;

  // Protection check on the live request; markings come from the registers
  // so a change takes effect at the edge after its pulse
  fbp_guard u_guard (
    .req_in(req_in),
    .prot_in(prot_reg),
    .deny_out(deny)
  );

  // Ready and busy come from the state register alone, so no path runs
  // from req_valid_in back to req_ready_out
  assign take = req_valid_in && (state_reg == FBP_IDLE);
  assign req_ready_out = (state_reg == FBP_IDLE);
  assign rsp_valid_out = rsp_valid_reg;
  assign rsp_out = rsp_reg;
  assign busy_out = (state_reg != FBP_IDLE);

  // Array read taps: the live address for reads, the held one for the
  // program merge; kept out of the sequencing process so that it is not
  // re-evaluated on every array write
  assign rd_word = mem[req_in.addr];
  assign old_word = mem[hold_reg.addr];

  // Markings: one entry per pair, each sees only pulses aimed at it
  // A change lands at the next edge; a request taken in the same cycle
  // is still judged against the old marking
  for (genvar gi = 0; gi < FBP_PAIRS; gi++) begin : g_mark
    always_comb begin
      prot_next[gi] = prot_reg[gi];
      if (prot_set_in && (prot_pair_in == FBP_PAIR_W'(gi))) begin
        prot_next[gi] = prot_val_in;
      end
    end
  end

  // Request sequencing: reads answer next cycle, writes wait for completion
  // Refusals and reads answer from idle in one cycle, so a requester can
  // stream them back to back with ready held high
  always_comb begin
    state_next = state_reg;
    hold_next = hold_reg;
    cnt_next = cnt_reg;
    ptr_next = ptr_reg;
    rsp_valid_next = 1'b0;
    rsp_next = rsp_reg;
    mem_we = 1'b0;
    mem_addr = hold_reg.addr;
    mem_wdata = hold_reg.wdata;
    unique case (state_reg)
      FBP_IDLE: begin
        if (take) begin
          // Refusal is judged on the live request; the hold only serves writes
          hold_next = req_in;
          if (deny) begin
            // Finish the transfer, leave the array alone
            rsp_valid_next = 1'b1;
            rsp_next.rdata = 32'h00000000;
            rsp_next.violation = 1'b1;
          end else if (req_in.op == FBP_OP_READ) begin
            rsp_valid_next = 1'b1;
            rsp_next.rdata = rd_word;
            rsp_next.violation = 1'b0;
          end else if (req_in.op == FBP_OP_PROGRAM) begin
            // Load the program timer; the word is written on its last count
            state_next = FBP_PROG;
            cnt_next = FBP_CNT_W'(FBP_PROG_CYC);
          end else begin
            state_next = FBP_ERASE;
            ptr_next = '0;
          end
        end
      end
      FBP_PROG: begin
        // Programming only clears bits, as flash cells do; a unit must be
        // erased before a word can get its ones back
        if (cnt_reg == FBP_CNT_W'(1)) begin
          mem_we = 1'b1;
          mem_wdata = old_word & hold_reg.wdata;
          state_next = FBP_IDLE;
          rsp_valid_next = 1'b1;
          rsp_next.rdata = 32'h00000000;
          rsp_next.violation = 1'b0;
        end else begin
          cnt_next = cnt_reg - FBP_CNT_W'(1);
        end
      end
      FBP_ERASE: begin
        // One word per cycle, only inside the addressed unit
        // Requests wait the whole 256 cycles; a unit-wide write port would
        // be quicker but would not map onto a plain memory
        mem_we = 1'b1;
        mem_addr = {hold_reg.addr[FBP_WORD_AW-1:FBP_UNIT_LSB], ptr_reg};
        mem_wdata = FBP_ERASED_WORD;
        ptr_next = ptr_reg + FBP_UNIT_AW'(1);
        // Last word of the unit is written this cycle; answer on the next
        if (ptr_reg == FBP_UNIT_LAST) begin
          state_next = FBP_IDLE;
          rsp_valid_next = 1'b1;
          rsp_next.rdata = 32'h00000000;
          rsp_next.violation = 1'b0;
        end
      end
      default: begin
        // The spare code is never entered; fall back to idle if it is
        state_next = FBP_IDLE;
      end
    endcase
  end

  // Request sequencing registers
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_reg <= FBP_IDLE;
      hold_reg <= '0;
      cnt_reg <= '0;
      ptr_reg <= '0;
    end else begin
      state_reg <= state_next;
      hold_reg <= hold_next;
      cnt_reg <= cnt_next;
      ptr_reg <= ptr_next;
    end
  end

  // Answer registers; reset leaves no stale answer pending
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rsp_valid_reg <= 1'b0;
      rsp_reg <= '0;
    end else begin
      rsp_valid_reg <= rsp_valid_next;
      rsp_reg <= rsp_next;
    end
  end

  // Marking registers; reset opens every pair
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      prot_reg <= '0;
    end else begin
      prot_reg <= prot_next;
    end
  end

  // Array write port; no reset so it maps to memory, contents start unknown
  // Only the sequencing process raises mem_we, never for a refused request
  always_ff @(posedge clk_in) begin
    if (mem_we) begin
      mem[mem_addr] <= mem_wdata;
    end
  end

endmodule : fbp_flash

//--- bench/fbp_flash_sva.sv
/* Checker for fbp_flash: refusals, answer timing, busy over the program span and the first 8 erase cycles.
   Assumes markings change only through prot_set_in. */
`timescale 1ns/100ps
module fbp_flash_sva (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic req_valid_in,
  input wire fbp_pkg::fbp_req_t req_in,
  input wire logic req_ready_out,
  input wire logic rsp_valid_out,
  input wire fbp_pkg::fbp_rsp_t rsp_out,
  input wire logic prot_set_in,
  input wire logic [fbp_pkg::FBP_PAIR_W-1:0] prot_pair_in,
  input wire fbp_pkg::fbp_prot_t prot_val_in,
  input wire logic busy_out
);
  import fbp_pkg::*;
  logic [255:0] mark_reg;
  fbp_prot_t pm;
  logic tk, wr, dn;
  // Shadow markings, so every refusal can be predicted
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) mark_reg <= '0;
    else if (prot_set_in) mark_reg[prot_pair_in*2 +: 2] <= prot_val_in;
  end
  assign pm = mark_reg[req_in.addr[15:9]*2 +: 2];
  assign tk = req_valid_in && req_ready_out;
  assign wr = req_in.op != FBP_OP_READ;
  // Both marks set counts as execute-only for reads
  assign dn = wr ? |pm : pm.exec_only && req_in.src != FBP_SRC_IFETCH;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_busy; busy_out && !req_ready_out; endsequence
  sequence s_ok; rsp_valid_out && !rsp_out.violation; endsequence
  sequence s_bad; rsp_valid_out && rsp_out.violation; endsequence
  property p_ro; tk && wr && pm.read_only |=> s_bad; endproperty
  a_ro: assert property (p_ro) else $error("read-only write taken");
  property p_xw; tk && wr && pm.exec_only |=> s_bad; endproperty
  a_xw: assert property (p_xw) else $error("execute-only write taken");
  property p_xr; tk && !wr && dn |=> s_bad and (rsp_out.rdata == 32'h0); endproperty
  a_xr: assert property (p_xr) else $error("execute-only read leaked");
  property p_rd; tk && !wr && !dn |=> s_ok; endproperty
  a_rd: assert property (p_rd) else $error("allowed read refused");
  property p_pg; tk && req_in.op == FBP_OP_PROGRAM && !dn |=> s_busy[*2] ##1 s_ok; endproperty
  a_pg: assert property (p_pg) else $error("program timing wrong");
  property p_er; tk && req_in.op == FBP_OP_ERASE && !dn |=> s_busy[*8] ##249 s_ok; endproperty
  a_er: assert property (p_er) else $error("erase timing wrong");
  property p_dn; tk && dn |=> s_bad and (!busy_out && req_ready_out); endproperty
  a_dn: assert property (p_dn) else $error("refusal not completed");
endmodule : fbp_flash_sva
bind fbp_flash fbp_flash_sva u_sva (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
  .req_valid_in(req_valid_in), .req_in(req_in), .req_ready_out(req_ready_out),
  .rsp_valid_out(rsp_valid_out), .rsp_out(rsp_out), .prot_set_in(prot_set_in),
  .prot_pair_in(prot_pair_in), .prot_val_in(prot_val_in), .busy_out(busy_out));

//--- bench/fbp_req_model.sv
/* Requester model: fetch, data and debug traffic, one at a time.
   Assumes every taken request is answered on rsp_valid_in. */
`timescale 1ns/100ps
module fbp_req_model (
  input wire logic clk_in,
  input wire logic req_ready_in,
  input wire logic rsp_valid_in,
  input wire fbp_pkg::fbp_rsp_t rsp_in,
  output fbp_pkg::fbp_req_t req_out = '0,
  output logic req_valid_out = 1'b0
);
  import fbp_pkg::*;
  // Hold until taken, then show inverted garbage so nothing leans on it
  task automatic xfer(input fbp_req_t r, output fbp_rsp_t a);
    req_out <= r;
    req_valid_out <= 1'b1;
    do @(posedge clk_in); while (req_ready_in !== 1'b1);
    req_valid_out <= 1'b0;
    req_out <= ~r;
    do @(posedge clk_in); while (rsp_valid_in !== 1'b1);
    a = rsp_in;
  endtask : xfer
endmodule : fbp_req_model

//--- bench/fbp_flash_tb.sv
/* Testbench for fbp_flash: erase, program and pair markings.
   Assumes fbp_req_model as the requester. */
`timescale 1ns/100ps
module fbp_flash_tb;
  import fbp_pkg::*;
  localparam fbp_src_t SF = FBP_SRC_IFETCH, SD = FBP_SRC_DATA, SG = FBP_SRC_DEBUG;
  localparam fbp_op_t RD = FBP_OP_READ, PG = FBP_OP_PROGRAM, ER = FBP_OP_ERASE;
  logic clk_in = 1'b0, sys_rst_in = 1'b1, prot_set_in = 1'b0;
  logic req_valid_in, req_ready_out, rsp_valid_out, busy_out;
  logic [6:0] prot_pair_in = 7'h00;
  fbp_prot_t prot_val_in = '0;
  fbp_req_t req_in;
  fbp_rsp_t rsp_out, r;
  int fails = 0, tests_run = 0, cyc = 0;
  initial begin
    forever #10 clk_in = ~clk_in;
  end
  fbp_flash dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .req_valid_in(req_valid_in),
    .req_in(req_in), .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
    .rsp_out(rsp_out), .prot_set_in(prot_set_in), .prot_pair_in(prot_pair_in),
    .prot_val_in(prot_val_in), .busy_out(busy_out));
  fbp_req_model u_req (.clk_in(clk_in), .req_ready_in(req_ready_out), .rsp_valid_in(rsp_valid_out),
    .rsp_in(rsp_out), .req_out(req_in), .req_valid_out(req_valid_in));
  // Write answers carry no data, so only the flag is compared there
  task automatic go(fbp_src_t s, fbp_op_t o, logic [15:0] a, logic [31:0] d, x, logic v);
    u_req.xfer('{s, o, a, d}, r);
    tests_run++;
    if ({o == RD ? r.rdata : x, r.violation} !== {x, v}) begin
      fails++;
      $display("ERROR %0t addr %h got %h", $time, a, r);
    end
  endtask : go
  task automatic mark(logic [6:0] p, fbp_prot_t m);
    prot_pair_in <= p;
    prot_val_in <= m;
    prot_set_in <= 1'b1;
    @(posedge clk_in);
    prot_set_in <= 1'b0;
  endtask : mark
  task automatic t_array();
    go(SD, ER, 16'h0000, 32'h0, 32'h0, 1'b0);
    go(SD, ER, 16'h0200, 32'h0, 32'h0, 1'b0);
    go(SG, RD, 16'h00FF, 32'h0, 32'hFFFFFFFF, 1'b0);
    go(SD, PG, 16'h0005, 32'h0000FFFF, 32'h0, 1'b0);
    go(SD, PG, 16'h0205, 32'h1234ABCD, 32'h0, 1'b0);
    go(SD, ER, 16'h0100, 32'h0, 32'h0, 1'b0);
    go(SD, RD, 16'h0005, 32'h0, 32'h0000FFFF, 1'b0);
  endtask : t_array
  task automatic t_read_only();
    mark(7'h00, 2'h2);
    go(SD, PG, 16'h0005, 32'h0, 32'h0, 1'b1);
    go(SG, ER, 16'h0100, 32'h0, 32'h0, 1'b1);
    go(SD, RD, 16'h0005, 32'h0, 32'h0000FFFF, 1'b0);
    go(SD, PG, 16'h0205, 32'hFFFF0000, 32'h0, 1'b0);
  endtask : t_read_only
  task automatic t_exec_only();
    mark(7'h01, 2'h1);
    go(SF, RD, 16'h0205, 32'h0, 32'h12340000, 1'b0);
    go(SD, RD, 16'h0205, 32'h0, 32'h0, 1'b1);
    go(SG, RD, 16'h0205, 32'h0, 32'h0, 1'b1);
    go(SF, PG, 16'h0205, 32'h0, 32'h0, 1'b1);
    go(SD, ER, 16'h0300, 32'h0, 32'h0, 1'b1);
    go(SF, RD, 16'h0205, 32'h0, 32'h12340000, 1'b0);
  endtask : t_exec_only
  task automatic finish_test();
    $display("fails %0d tests_run %0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test
  initial begin
    repeat (5) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_in);
    t_array();
    t_read_only();
    t_exec_only();
    finish_test();
  end
  // Three erases dominate the run, so 3000 cycles is ample
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      finish_test();
    end
  end
endmodule : fbp_flash_tb
